// ### logic/fad_access_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fad_access_chk #(
    parameter int MAX_BYTES = fad_pkg::MAX_BYTES
) (
    input wire fad_pkg::fad_fetch_t fetch_i, // Fetch translation info
    input wire fad_pkg::fad_data_t data_i, // Data translation info
    input wire logic [31:0] dbrk_i, // Data breakpoint address
    output logic if_fault_o, // Fetch fault, combinational
    output logic da_fault_o // Data fault, combinational
);
    logic [4:0] len;
    logic [3:0] mask;
    logic misalign;
    logic [MAX_BYTES-1:0] bp_hit;

    if (MAX_BYTES != 16) begin : g_chk
        $error("fad_access_chk serves 16-byte operands only");
    end

    assign len = 5'h1 << data_i.size;
    assign mask = 4'(len - 5'h1);
    assign misalign = (data_i.size > fad_pkg::OPSZ_MAX) ||
                      ((data_i.addr[3:0] & mask) != 4'h0); // see [RULE_20]

    // Each byte the operand spans is compared on its own address
    for (genvar i = 0; i < MAX_BYTES; i++) begin : g_bp
        assign bp_hit[i] = (5'(i) < len) &&
                           (data_i.addr + 32'(i) == dbrk_i); // see [RULE_21]
    end

    // Protection is only seen when a whole group is fetched
    assign if_fault_o = fetch_i.vld && (!fetch_i.dir_present ||
                        !fetch_i.tbl_present ||
                        (fetch_i.user && fetch_i.super_pg) ||
                        (fetch_i.locked && !fetch_i.accessed)); // see [RULE_16] see [RULE_17]

    assign da_fault_o = data_i.vld && (!data_i.present ||
                        (data_i.write && !data_i.dirty) ||
                        (data_i.user && data_i.super_pg) || // see [RULE_18]
                        (data_i.locked && !data_i.accessed) ||
                        misalign || (|bp_hit)); // see [RULE_19]
endmodule // fad_access_chk
`default_nettype wire

// ### logic/fad_fault_detect.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE_01] Special operand into adder or multiplier faults and sets source flag.
// [RULE_02] Source fault reported on starting instruction; pipe holds; tag recorded.
// [RULE_03] Source flag undefined for load, store, transfer faults.
// [RULE_04] Overflow flagged; underflow flagged only while flush control clear.
// [RULE_05] Inexact flagged only while trap-on-inexact control set.
// [RULE_06] Scalar result exception reported on next fp or extended store.
// [RULE_07] Pipelined result exception reported from last stage; pipe holds.
// [RULE_08] Load or transfer traps on overlap, else only if excepting op finished.
// [RULE_09] Trap enable clear or no exception: pipe advances, no trap.
// [RULE_10] Last-stage status of both units shown once exceptions reported.
// [RULE_11] Multiplier overflow pending and pipelined add starts: trap, set flag.
// [RULE_12] Result register field loaded at scalar start, cleared for pipelined.
// [RULE_13] Supplied result keeps true mantissa and low exponent bits.
// [RULE_14] Adder overflow exponent all ones for fp, below for conversion.
// [RULE_15] Adder and multiplier exceptions may report together in one trap.
// [RULE_16] Fetch faults: not present, supervisor page in user, locked unaccessed.
// [RULE_17] Fetch protection checked per fetched group only.
// [RULE_18] User mode data access to supervisor page refused.
// [RULE_19] Data faults: clean write, not present, protection, locked unaccessed.
// [RULE_20] Misaligned memory operand raises data fault.
// [RULE_21] Breakpoint address inside operand span raises data fault.
// [RULE_22] Data trap may leave next pipelined fp destination partly written.
// [RULE_23] Fp faults only on fp and memory/transfer ops; moves never fault.
// [RULE_24] One trap request with cause, same cycle as pipeline hold.
module fad_fault_detect (
    input wire logic mclk_i, // Core clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic hsel_i, // AHB select
    input wire logic [31:0] haddr_i, // AHB address
    input wire logic [1:0] htrans_i, // AHB transfer type
    input wire logic hwrite_i, // AHB write
    input wire logic [2:0] hsize_i, // AHB size
    input wire logic hready_i, // AHB bus ready
    input wire logic [31:0] hwdata_i, // AHB write data
    output logic hreadyout_o, // AHB slave ready
    output logic hresp_o, // AHB response, always OKAY
    output logic [31:0] hrdata_o, // AHB read data
    input wire fad_pkg::fad_issue_t iss_i, // Instruction at issue
    input wire fad_pkg::fad_unit_t add_i, // Adder result report
    input wire fad_pkg::fad_unit_t mul_i, // Multiplier result report
    input wire fad_pkg::fad_fetch_t fetch_i, // Fetch translation
    input wire fad_pkg::fad_data_t data_i, // Data translation
    output logic trap_o, // Trap request pulse
    output logic [2:0] cause_o, // Trap cause bits
    output logic stall_o, // Hold pipeline advance
    output logic [4:0] rr_o, // Result register field
    output fad_pkg::fad_res_t sup_add_o, // Adder supplied result
    output fad_pkg::fad_res_t sup_mul_o // Multiplier supplied result
);
    typedef struct packed {
        logic [2:0] ctrl;
        logic se;
        logic [7:0] add_rs;
        logic [7:0] mul_rs;
        logic [4:0] rr;
        logic [31:0] dbrk;
        logic [31:0] fins;
        logic [2:0] last_cause;
        logic pa;
        logic pa_done;
        logic [4:0] pa_dest;
        logic pa_dbl;
        logic [7:0] pa_rs;
        logic pm;
        logic pm_done;
        logic [4:0] pm_dest;
        logic pm_dbl;
        logic [7:0] pm_rs;
        fad_pkg::fad_res_t sup_a;
        fad_pkg::fad_res_t sup_m;
        logic trap;
        logic stall;
        logic [2:0] cause;
        logic ap_vld;
        logic ap_wr;
        logic ap_ok;
        logic [7:0] ap_addr;
        logic hready;
        logic [31:0] hrdata;
    } fad_state_t;

    localparam logic [fad_pkg::EXP_W-1:0] EXP_BELOW_ONES =
        {{(fad_pkg::EXP_W-1){1'b1}}, 1'b0};

    fad_state_t s;
    fad_state_t n;
    logic if_f;
    logic da_f;
    logic fp_trap_enable;
    logic fz;
    logic ti;
    logic exc_a;
    logic exc_m;
    logic is_rep;
    logic is_ldx;
    logic is_arith;
    logic is_scalar;
    logic src_bad;
    logic res_hit;
    logic fp_trap;
    logic [31:0] rdata;

    fad_access_chk #(
        .MAX_BYTES(fad_pkg::MAX_BYTES)
    ) u_acc (
        .fetch_i(fetch_i),
        .data_i(data_i),
        .dbrk_i(s.dbrk),
        .if_fault_o(if_f),
        .da_fault_o(da_f)
    );

    function automatic logic special(input logic [fad_pkg::EXP_W-1:0] e,
                                     input logic [fad_pkg::MANT_W-1:0] m);
        // Infinity, NaN or denormal
        return (&e) || ((e == '0) && (m != '0)); // see [RULE_01]
    endfunction

    function automatic logic [7:0] rs_bits(input fad_pkg::fad_unit_t u,
                                           input logic fzc, input logic tic);
        logic [7:0] r;
        r = 8'h00;
        r[fad_pkg::RS_OVF] = u.ovf; // see [RULE_04]
        r[fad_pkg::RS_UNF] = u.unf && !fzc; // see [RULE_04]
        r[fad_pkg::RS_INX] = u.inx && tic; // see [RULE_05]
        return r;
    endfunction

    function automatic fad_pkg::fad_res_t supply(input fad_pkg::fad_unit_t u,
                                                 input logic is_add);
        fad_pkg::fad_res_t r;
        r.mant = u.mant; // see [RULE_13]
        r.exp = u.exp_true[fad_pkg::EXP_W-1:0]; // see [RULE_13]
        // Lets the handler tell a conversion overflow from a true one
        if (is_add && u.ovf && !u.conv) begin
            r.exp = '1; // see [RULE_14]
        end else if (is_add && u.ovf && u.conv && (&r.exp)) begin
            r.exp = EXP_BELOW_ONES; // see [RULE_14]
        end
        return r;
    endfunction

    function automatic logic overlap(input logic [4:0] da, input logic dba,
                                     input logic [4:0] db, input logic dbb);
        return (da[4:1] == db[4:1]) && (dba || dbb || (da[0] == db[0]));
    endfunction

    always_comb begin
        rdata = 32'h0000_0000;
        if (s.ap_ok) begin
            case (s.ap_addr)
                fad_pkg::OFF_CTRL: rdata[2:0] = s.ctrl;
                fad_pkg::OFF_STAT: begin
                    rdata[fad_pkg::STAT_SE] = s.se;
                    rdata[fad_pkg::STAT_ADD_LO +: 8] = s.add_rs;
                    rdata[fad_pkg::STAT_RR_LO +: 5] = s.rr;
                    rdata[fad_pkg::STAT_MUL_LO +: 8] = s.mul_rs;
                end
                fad_pkg::OFF_DBRK: rdata = s.dbrk;
                fad_pkg::OFF_FINS: rdata = s.fins;
                fad_pkg::OFF_CAUSE: rdata[2:0] = s.last_cause;
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        n = s;
        n.trap = 1'b0;
        n.stall = 1'b0;
        n.cause = 3'h0;
        fp_trap_enable = s.ctrl[fad_pkg::CTRL_FTE];
        fz = s.ctrl[fad_pkg::CTRL_FZ];
        ti = s.ctrl[fad_pkg::CTRL_TI];
        exc_a = |rs_bits(add_i, fz, ti);
        exc_m = |rs_bits(mul_i, fz, ti);
        // Plain moves are not checked for operand validity
        is_arith = iss_i.valid && (iss_i.kind inside {fad_pkg::K_ADD_S,
                   fad_pkg::K_ADD_P, fad_pkg::K_MUL_S,
                   fad_pkg::K_MUL_P}); // see [RULE_23]
        is_scalar = iss_i.kind inside {fad_pkg::K_ADD_S, fad_pkg::K_MUL_S};
        is_rep = iss_i.valid && (is_arith ||
                 iss_i.kind inside {fad_pkg::K_FP_OTHER,
                 fad_pkg::K_STORE_X}); // see [RULE_06] see [RULE_07]
        is_ldx = iss_i.valid && (iss_i.kind == fad_pkg::K_LOADX);
        src_bad = is_arith && (special(iss_i.a_exp, iss_i.a_mant) ||
                  special(iss_i.b_exp, iss_i.b_mant));
        res_hit = fp_trap_enable && ((is_rep && (s.pa || s.pm)) ||
                  (is_ldx && ((s.pa && (s.pa_done || overlap(s.pa_dest,
                  s.pa_dbl, iss_i.dest, iss_i.dbl))) ||
                  (s.pm && (s.pm_done || overlap(s.pm_dest,
                  s.pm_dbl, iss_i.dest, iss_i.dbl)))))); // see [RULE_08]
        fp_trap = res_hit || (fp_trap_enable && src_bad); // see [RULE_09]

        // Register bus: every data phase takes one wait state
        n.hready = 1'b1;
        if (s.ap_vld) begin
            n.ap_vld = 1'b0;
            if (!s.ap_wr) begin
                n.hrdata = rdata;
            end else if (s.ap_ok) begin
                case (s.ap_addr)
                    fad_pkg::OFF_CTRL: n.ctrl = hwdata_i[2:0];
                    fad_pkg::OFF_STAT: begin
                        n.se = s.se && !hwdata_i[fad_pkg::STAT_SE];
                        n.add_rs = s.add_rs &
                                   ~hwdata_i[fad_pkg::STAT_ADD_LO +: 8];
                        n.mul_rs = s.mul_rs &
                                   ~hwdata_i[fad_pkg::STAT_MUL_LO +: 8];
                        n.rr = hwdata_i[fad_pkg::STAT_RR_LO +: 5];
                    end
                    fad_pkg::OFF_DBRK: n.dbrk = hwdata_i;
                    default: n.dbrk = s.dbrk;
                endcase
            end
        end else if (hsel_i && htrans_i[1] && hready_i) begin
            n.ap_vld = 1'b1;
            n.ap_wr = hwrite_i;
            n.ap_ok = (hsize_i == fad_pkg::HSIZE_WORD) &&
                      (haddr_i[31:8] == 24'h00_0000);
            n.ap_addr = haddr_i[7:0];
            n.hready = 1'b0;
        end

        // Hardware sets after the software clear, so a set wins
        if (src_bad) begin
            n.se = 1'b1; // see [RULE_01] see [RULE_03]
        end
        if (res_hit) begin
            n.add_rs = s.pa ? s.pa_rs : 8'h00; // see [RULE_10]
            n.mul_rs = s.pm ? s.pm_rs : 8'h00; // see [RULE_11] see [RULE_15]
            n.pa = 1'b0;
            n.pm = 1'b0;
        end
        // With traps off nothing is held for later reporting
        if (fp_trap_enable && add_i.early && exc_a) begin
            n.pa = 1'b1;
            n.pa_done = 1'b0;
            n.pa_dest = add_i.dest;
            n.pa_dbl = add_i.dbl;
        end
        if (fp_trap_enable && add_i.fin && exc_a) begin
            n.pa = 1'b1;
            n.pa_done = 1'b1;
            n.pa_dest = add_i.dest;
            n.pa_dbl = add_i.dbl;
            n.pa_rs = rs_bits(add_i, fz, ti);
            n.sup_a = supply(add_i, 1'b1);
        end
        if (fp_trap_enable && mul_i.early && exc_m) begin
            n.pm = 1'b1;
            n.pm_done = 1'b0;
            n.pm_dest = mul_i.dest;
            n.pm_dbl = mul_i.dbl;
        end
        if (fp_trap_enable && mul_i.fin && exc_m) begin
            n.pm = 1'b1;
            n.pm_done = 1'b1;
            n.pm_dest = mul_i.dest;
            n.pm_dbl = mul_i.dbl;
            n.pm_rs = rs_bits(mul_i, fz, ti);
            n.sup_m = supply(mul_i, 1'b0);
        end

        n.cause[fad_pkg::CAUSE_FP] = fp_trap; // see [RULE_02]
        n.cause[fad_pkg::CAUSE_IF] = if_f; // see [RULE_16] see [RULE_17]
        // Data traps do not cancel the next pipelined write back
        n.cause[fad_pkg::CAUSE_DA] = da_f; // see [RULE_19] see [RULE_22]
        n.trap = |n.cause; // see [RULE_24]
        n.stall = |n.cause; // see [RULE_02] see [RULE_07]
        if (n.trap) begin
            n.fins = iss_i.tag; // see [RULE_02]
            n.last_cause = n.cause;
        end else if (is_arith) begin
            n.rr = is_scalar ? iss_i.dest : 5'h00; // see [RULE_12]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s <= '0;
            s.ctrl <= fad_pkg::CTRL_RST;
            s.hready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hreadyout_o = s.hready;
    assign hresp_o = 1'b0;
    assign hrdata_o = s.hrdata;
    assign trap_o = s.trap;
    assign cause_o = s.cause;
    assign stall_o = s.stall;
    assign rr_o = s.rr;
    assign sup_add_o = s.sup_a;
    assign sup_mul_o = s.sup_m;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_addr_taken;
        hsel_i && htrans_i[1] && hready_i && !s.ap_vld;
    endsequence
    sequence s_wait_ready;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    sequence s_trap_now(bit c);
        trap_o && stall_o && c;
    endsequence

    a_bus_wait_one: assert property (s_addr_taken |=> s_wait_ready)
        else $error("Data phase is not one wait state");
    a_src_fault: assert property ( // see [RULE_01]
        src_bad && fp_trap_enable |=> s_trap_now(cause_o[fad_pkg::CAUSE_FP] && s.se))
        else $error("Special operand did not trap");
    a_fault_tag: assert property ( // see [RULE_02]
        trap_o |-> s.fins == $past(iss_i.tag))
        else $error("Fault instruction tag wrong");
    a_res_report: assert property ( // see [RULE_07]
        fp_trap_enable && (s.pa || s.pm) && iss_i.valid &&
        iss_i.kind == fad_pkg::K_STORE_X |=>
        s_trap_now(cause_o[fad_pkg::CAUSE_FP]))
        else $error("Pending result exception not reported");
    a_no_trap_off: assert property ( // see [RULE_09]
        !fp_trap_enable && !if_f && !da_f |=> !trap_o && !stall_o)
        else $error("Trap with traps disabled");
    a_both_units: assert property ( // see [RULE_15]
        res_hit && s.pa && s.pm |=>
        s.add_rs == $past(s.pa_rs) && s.mul_rs == $past(s.pm_rs))
        else $error("Both unit status not shown");
    a_mul_ovf: assert property ( // see [RULE_11]
        fp_trap_enable && s.pm && s.pm_rs[fad_pkg::RS_OVF] && iss_i.valid &&
        iss_i.kind == fad_pkg::K_ADD_P |=> s.mul_rs[fad_pkg::RS_OVF] && trap_o)
        else $error("Multiplier overflow flag not set");
    a_rr_scalar: assert property ( // see [RULE_12]
        is_arith && is_scalar && !n.trap |=> rr_o == $past(iss_i.dest))
        else $error("Result register field not loaded");
    a_rr_pipe: assert property ( // see [RULE_12]
        is_arith && !is_scalar && !n.trap |=> rr_o == 5'h00)
        else $error("Result register field not cleared");
    a_sup_mant: assert property ( // see [RULE_13]
        fp_trap_enable && add_i.fin && exc_a |=> sup_add_o.mant == $past(add_i.mant))
        else $error("Supplied mantissa differs");
    a_add_ovf_exp: assert property ( // see [RULE_14]
        fp_trap_enable && add_i.fin && add_i.ovf |=>
        ($past(add_i.conv) ? !(&sup_add_o.exp) : (&sup_add_o.exp)))
        else $error("Adder overflow exponent wrong");
    a_fetch_user: assert property ( // see [RULE_16]
        fetch_i.vld && fetch_i.user && fetch_i.super_pg |=>
        s_trap_now(cause_o[fad_pkg::CAUSE_IF]))
        else $error("User fetch of supervisor page not trapped");
    a_data_user: assert property ( // see [RULE_18]
        data_i.vld && data_i.user && data_i.super_pg |=>
        s_trap_now(cause_o[fad_pkg::CAUSE_DA]))
        else $error("User data access to supervisor page allowed");
    a_misalign: assert property ( // see [RULE_20]
        data_i.vld && data_i.size == 3'h2 && data_i.addr[1:0] != 2'h0 |=>
        cause_o[fad_pkg::CAUSE_DA])
        else $error("Misaligned word not trapped");
    a_dbrk_hit: assert property ( // see [RULE_21]
        data_i.vld && data_i.addr == s.dbrk |=> cause_o[fad_pkg::CAUSE_DA])
        else $error("Breakpoint hit not trapped");
    a_trap_cause: assert property ( // see [RULE_24]
        trap_o |-> stall_o && cause_o != 3'h0 && s.last_cause == cause_o)
        else $error("Trap without hold or cause");
endmodule // fad_fault_detect
`default_nettype wire

// ### logic/fad_pkg.sv
`default_nettype none
package fad_pkg;
    localparam int EXP_W = 8;
    localparam int MANT_W = 23;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DBRK = 8'h08;
    localparam logic [7:0] OFF_FINS = 8'h0C;
    localparam logic [7:0] OFF_CAUSE = 8'h10;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int CTRL_FTE = 0;
    localparam int CTRL_FZ = 1;
    localparam int CTRL_TI = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam int STAT_SE = 8;
    localparam int STAT_ADD_LO = 9;
    localparam int STAT_RR_LO = 17;
    localparam int STAT_MUL_LO = 22;
    localparam int RS_OVF = 0;
    localparam int RS_UNF = 1;
    localparam int RS_INX = 2;
    localparam int CAUSE_FP = 0;
    localparam int CAUSE_IF = 1;
    localparam int CAUSE_DA = 2;
    localparam logic [2:0] OPSZ_MAX = 3'h4;
    localparam int MAX_BYTES = 16;

    typedef enum logic [3:0] {
        K_NONE, K_ADD_S, K_ADD_P, K_MUL_S, K_MUL_P,
        K_FP_OTHER, K_STORE_X, K_LOADX, K_STORE
    } fad_kind_t;

    typedef struct packed {
        logic valid;
        fad_kind_t kind;
        logic dual;
        logic comp_fp;
        logic [4:0] dest;
        logic dbl;
        logic [31:0] tag;
        logic [EXP_W-1:0] a_exp;
        logic [MANT_W-1:0] a_mant;
        logic [EXP_W-1:0] b_exp;
        logic [MANT_W-1:0] b_mant;
    } fad_issue_t;

    typedef struct packed {
        logic early;
        logic fin;
        logic ovf;
        logic unf;
        logic inx;
        logic conv;
        logic [4:0] dest;
        logic dbl;
        logic [MANT_W-1:0] mant;
        logic [EXP_W+1:0] exp_true;
    } fad_unit_t;

    typedef struct packed {
        logic [MANT_W-1:0] mant;
        logic [EXP_W-1:0] exp;
    } fad_res_t;

    typedef struct packed {
        logic vld;
        logic user;
        logic locked;
        logic dir_present;
        logic tbl_present;
        logic super_pg;
        logic accessed;
    } fad_fetch_t;

    typedef struct packed {
        logic vld;
        logic write;
        logic user;
        logic locked;
        logic present;
        logic super_pg;
        logic dirty;
        logic accessed;
        logic [31:0] addr;
        logic [2:0] size;
    } fad_data_t;
endpackage
`default_nettype wire

// ### verification/fad_fault_detect_test.sv
`timescale 1ns/10ps
`default_nettype none
module fad_fault_detect_test;
    logic mclk_i, rst_i, hsel, hwrite, hready, hresp, trap, stall, bad;
    logic [1:0] htrans;
    logic [2:0] hsize, cause;
    logic [4:0] rr;
    logic [7:0] traps;
    logic [31:0] haddr, hwdata, hrdata, rd;
    fad_pkg::fad_issue_t iss;
    fad_pkg::fad_unit_t au, mu;
    fad_pkg::fad_fetch_t fet;
    fad_pkg::fad_data_t dat;
    fad_pkg::fad_res_t sa, sm;
    typedef struct packed {
        fad_pkg::fad_fetch_t f;
        fad_pkg::fad_data_t d;
        logic [2:0] c;
    } fad_row_t;
    fad_row_t rows [16];
    int num_errors = 0;
    int comparisons = 0;
    int exp_traps = 0;
    localparam logic [6:0] N = 7'b0001011;

    fad_fault_detect i_fad_fault_detect (.mclk_i(mclk_i), .rst_i(rst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hready_i(hready), .hwdata_i(hwdata),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .iss_i(iss), .add_i(au), .mul_i(mu), .fetch_i(fet), .data_i(dat),
        .trap_o(trap), .cause_o(cause), .stall_o(stall), .rr_o(rr),
        .sup_add_o(sa), .sup_mul_o(sm));
    fad_trap_seq_model i_fad_trap_seq_model (.mclk_i(mclk_i), .rst_i(rst_i),
        .trap_i(trap), .stall_i(stall), .traps_o(traps), .bad_o(bad));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic report_and_stop;
        $display("comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        report_and_stop;
    end

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
        @(posedge mclk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= fad_pkg::HSIZE_WORD;
        do @(posedge mclk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        // Only the watchdog ends a wait that never finishes
        do @(posedge mclk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(rd, exp);
        check(32'(hresp), 32'h0);
    endtask

    function automatic fad_pkg::fad_issue_t op(fad_pkg::fad_kind_t k,
            logic [4:0] d, logic [7:0] e);
        return {1'b1, k, 2'b00, d, 1'b0, {27'h0000000, d}, e, 23'h000001,
            8'h40, 23'h000000};
    endfunction

    // Flags are ovf, unf, inx; result lands in register 7
    function automatic fad_pkg::fad_unit_t un(logic [2:0] f, logic [9:0] e);
        return {2'b01, f, 1'b0, 5'h07, 1'b0, 23'h012345, e};
    endfunction

    task automatic step(fad_pkg::fad_issue_t i, fad_pkg::fad_unit_t a,
            fad_pkg::fad_unit_t m, fad_row_t r);
        @(posedge mclk_i);
        iss <= i;
        au <= a;
        mu <= m;
        fet <= r.f;
        dat <= r.d;
        @(posedge mclk_i);
        iss <= '0;
        au <= '0;
        mu <= '0;
        fet <= '0;
        dat <= '0;
        #1;
        check(32'(trap), 32'(|r.c));
        check(32'(cause), 32'(r.c));
        check(32'(stall), 32'(|r.c));
        exp_traps = exp_traps + int'(|r.c);
    endtask

    task automatic fp(fad_pkg::fad_issue_t i, fad_pkg::fad_unit_t a,
            fad_pkg::fad_unit_t m, logic [2:0] c);
        step(i, a, m, {50'h0, c});
    endtask

    initial begin
        rst_i = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {iss, au, mu, fet, dat} = '0;
        rows[0] = {1'b1, 6'b001101, 43'h0, 3'h0};
        rows[1] = {1'b1, 6'b000101, 43'h0, 3'h2};
        rows[2] = {1'b1, 6'b001001, 43'h0, 3'h2};
        rows[3] = {1'b1, 6'b101111, 43'h0, 3'h2};
        rows[4] = {1'b1, 6'b011100, 43'h0, 3'h2};
        rows[5] = {1'b1, 6'b011111, 43'h0, 3'h0};
        rows[6] = {8'h01, 7'b1001011, 32'h100, 3'h2, 3'h0};
        rows[7] = {8'h01, 7'b1001001, 32'h100, 3'h2, 3'h4};
        rows[8] = {8'h01, 7'b0000011, 32'h100, 3'h2, 3'h4};
        rows[9] = {8'h01, 7'b0101111, 32'h100, 3'h2, 3'h4};
        rows[10] = {8'h01, 7'b0011010, 32'h100, 3'h2, 3'h4};
        rows[11] = {8'h01, N, 32'h102, 3'h2, 3'h4};
        rows[12] = {8'h01, N, 32'hFF0, 3'h4, 3'h0};
        rows[13] = {8'h01, N, 32'h1000, 3'h4, 3'h4};
        rows[14] = {8'h01, N, 32'h1000, 3'h0, 3'h4};
        rows[15] = {8'h01, N, 32'hFFC, 3'h2, 3'h0};
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        rdchk(fad_pkg::OFF_CTRL, 32'h0);
        rdchk(fad_pkg::OFF_STAT, 32'h0);
        bus(1'b1, 8'h14, 32'hFFFFFFFF);
        rdchk(8'h14, 32'h0);
        $display("test done: reset and map");
        bus(1'b1, fad_pkg::OFF_DBRK, 32'h00001000);
        for (int k = 0; k < 16; k++)
            step('0, '0, '0, rows[k]);
        $display("test done: access table");
        bus(1'b1, fad_pkg::OFF_CTRL, 32'h1);
        fp(op(fad_pkg::K_ADD_P, 5'h03, 8'hFF), '0, '0, 3'h1);
        rdchk(fad_pkg::OFF_STAT, 32'h100);
        rdchk(fad_pkg::OFF_FINS, 32'h3);
        fp(op(fad_pkg::K_MUL_S, 5'h04, 8'h00), '0, '0, 3'h1);
        bus(1'b1, fad_pkg::OFF_CTRL, 32'h0);
        bus(1'b1, fad_pkg::OFF_STAT, 32'h100);
        fp(op(fad_pkg::K_ADD_P, 5'h03, 8'hFF), '0, '0, 3'h0);
        rdchk(fad_pkg::OFF_STAT, 32'h100);
        bus(1'b1, fad_pkg::OFF_STAT, 32'h100);
        bus(1'b1, fad_pkg::OFF_CTRL, 32'h1);
        $display("test done: source faults");
        fp('0, '0, un(3'h4, 10'h305), 3'h0);
        fp(op(fad_pkg::K_ADD_P, 5'h09, 8'h40), '0, '0, 3'h1);
        check({1'b0, sm}, {1'b0, 23'h012345, 8'h05});
        check(32'(rr), 32'h0);
        rdchk(fad_pkg::OFF_STAT, 32'h00400000);
        fp(op(fad_pkg::K_ADD_S, 5'h07, 8'h40), '0, '0, 3'h0);
        check(32'(rr), 32'h7);
        fp('0, un(3'h4, 10'h123), '0, 3'h0);
        fp(op(fad_pkg::K_FP_OTHER, 5'h02, 8'h40), '0, '0, 3'h1);
        check({1'b0, sa}, {1'b0, 23'h012345, 8'hFF});
        fp('0, un(3'h4, 10'h123), '0, 3'h0);
        fp(op(fad_pkg::K_LOADX, 5'h07, 8'h40), '0, '0, 3'h1);
        fp('0, un(3'h4, 10'h123), '0, 3'h0);
        fp(op(fad_pkg::K_STORE, 5'h01, 8'hFF), '0, '0, 3'h0);
        fp(op(fad_pkg::K_STORE_X, 5'h01, 8'h40), '0, '0, 3'h1);
        $display("test done: result faults");
        bus(1'b1, fad_pkg::OFF_CTRL, 32'h3);
        fp('0, un(3'h2, 10'h001), '0, 3'h0);
        fp(op(fad_pkg::K_ADD_P, 5'h09, 8'h40), '0, '0, 3'h0);
        fp('0, un(3'h1, 10'h041), '0, 3'h0);
        fp(op(fad_pkg::K_ADD_P, 5'h09, 8'h40), '0, '0, 3'h0);
        bus(1'b1, fad_pkg::OFF_CTRL, 32'h5);
        fp('0, un(3'h1, 10'h041), '0, 3'h0);
        fp(op(fad_pkg::K_ADD_P, 5'h09, 8'h40), '0, '0, 3'h1);
        // Result register field is a plain write, so it reads back all ones
        bus(1'b1, fad_pkg::OFF_STAT, 32'hFFFFFFFF);
        fp('0, un(3'h4, 10'h041), un(3'h4, 10'h041), 3'h0);
        fp(op(fad_pkg::K_ADD_P, 5'h09, 8'h40), '0, '0, 3'h1);
        rdchk(fad_pkg::OFF_STAT, 32'h007E0200);
        $display("test done: gating and pairs");
        check(32'(traps), 32'(exp_traps));
        check(32'(bad), 32'h0);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        check(32'(rr), 32'h0);
        check({1'b0, sa}, 32'h0);
        rdchk(fad_pkg::OFF_CTRL, 32'h0);
        rdchk(fad_pkg::OFF_STAT, 32'h0);
        $display("test done: reset again");
        report_and_stop;
    end
endmodule // fad_fault_detect_test
`default_nettype wire

// ### verification/fad_trap_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module fad_trap_seq_model (
    input wire logic mclk_i, // Core clock
    input wire logic rst_i, // Sync reset
    input wire logic trap_i, // Trap request
    input wire logic stall_i, // Pipeline hold
    output logic [7:0] traps_o, // Traps taken
    output logic bad_o // Hold and trap apart
);
    // A trap without its hold would let the pipe run past the fault
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            traps_o <= 8'h00;
            bad_o <= 1'b0;
        end else begin
            traps_o <= traps_o + {7'h00, trap_i};
            bad_o <= bad_o | (trap_i ^ stall_i);
        end
    end
endmodule // fad_trap_seq_model
`default_nettype wire
